// *** mas_pkg.sv ***
/*
 * mas_pkg: register offsets, field positions, reset values and channel codes
 * for the monitor converter sequencer.
 * assumes: byte-wide register port with 8-bit offsets.
 */
package mas_pkg;

    // register offsets
    localparam logic [7:0] OFS_RESULT_HIGH_BYTE    = 8'h07;
    localparam logic [7:0] OFS_RESULT_LOW_BITS     = 8'h08;
    localparam logic [7:0] OFS_CONVERTER_SETUP_ONE = 8'h09;
    localparam logic [7:0] OFS_CONVERTER_SETUP_TWO = 8'h0A;

    // converter_setup_one fields
    localparam int BIT_CONVERTER_ENABLE  = 7;
    localparam int BIT_SINGLE_PASS       = 6;
    localparam int BIT_ALL_CHANNEL_SWEEP = 5;
    localparam int BIT_BUFFER_BYPASS     = 4;
    localparam int BIT_INPUT_SWAP        = 3;
    localparam int REV_HI                = 2;
    localparam int REV_LO                = 0;

    // converter_setup_two fields
    localparam int BIT_RESULT_VALID      = 7;
    localparam int RDSEL_HI              = 5;
    localparam int RDSEL_LO              = 3;
    localparam int CVSEL_HI              = 2;
    localparam int CVSEL_LO              = 0;

    // result layout
    localparam int RESULT_W              = 14;
    localparam int RES_HIGH_LO           = 6;
    localparam int CHAN_W                = 3;
    localparam int NUM_CHAN              = 8;

    // reset values
    localparam logic [4:0] SETUP_ONE_RST = 5'h00;
    localparam logic [5:0] SETUP_TWO_RST = 6'h00;
    localparam logic [7:0] RDATA_RST     = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // channel codes
    localparam logic [2:0] CH_INPUT_LIMIT_PIN         = 3'h0;
    localparam logic [2:0] CH_INPUT_VOLTAGE           = 3'h1;
    localparam logic [2:0] CH_BATTERY_VOLTAGE         = 3'h2;
    localparam logic [2:0] CH_OUTPUT_LIMIT_INPUT      = 3'h3;
    localparam logic [2:0] CH_THERMISTOR_INPUT        = 3'h4;
    localparam logic [2:0] CH_DIE_TEMPERATURE         = 3'h5;
    localparam logic [2:0] CH_EXTERNAL_INPUT          = 3'h6;
    localparam logic [2:0] CH_ANALOG_GROUND_REFERENCE = 3'h7;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        MAS_IDLE  = 4'h1,
        MAS_START = 4'h2,
        MAS_WAIT  = 4'h4,
        MAS_HALT  = 4'h8
    } mas_state_t;

endpackage : mas_pkg

// *** mas_result_store.sv ***
/*
 * mas_result_store: one stored result per channel, written when a
 * conversion ends and read back by channel.
 * assumes: write and read channels are synchronous to clk_i.
 */
`timescale 1ns/1ps
module mas_result_store #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // write side
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_ch_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // read side
    input  wire logic [AW-1:0]    rd_ch_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] store [DEPTH];

    // one slot per channel so a read never waits on the running conversion
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                store[i] <= '0;
            end
        end else if (wr_en_i) begin
            store[wr_ch_i] <= wr_data_i;
        end
    end

    assign rd_data_o = store[rd_ch_i];

endmodule : mas_result_store

// *** mas_sequencer.sv ***
/*
 * mas_sequencer: register file and channel sequencer of the monitor converter.
 * assumes: a register port decoded from the serial host link, one-cycle read
 * and write strobes, and an analog converter that answers each start pulse
 * with a one-cycle done pulse carrying the result.
 */
//
// Overview of operation
// - converts only while enable is set, and keeps converting while single-pass is clear.
// - single-pass and sweep both clear repeat the selected conversion channel forever.
// - sweep set with single-pass clear converts channels 0 to 7 in turn and restarts endlessly.
// - single-pass set with sweep clear converts the selected channel once and stops.
// - single-pass and sweep both set convert channels 0 to 7 once and then halt.
// - a read-only result-valid flag in the top bit of the second setup register marks fresh data.
// - the three-bit conversion channel select picks one of the eight monitored inputs.
// - the three-bit readback channel select picks which stored result the result registers show.
// - a result is kept per channel so one channel can be read while another converts.
// - the first result register shows result bits 13 down to 6.
// - the second result register shows result bits 5 to 0 with its top two bits reading zero.
// - the swap bit exchanges the two buffer inputs, clear leaves them in normal order.
// - the low three bits of the first setup register hold a fixed silicon revision code.
`timescale 1ns/1ps
module mas_sequencer #(
    // arbitrary value, not a real revision
    parameter logic [2:0] SILICON_REVISION = 3'h0
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // converter
    output logic             conv_start_o,
    output logic      [2:0]  conv_channel_o,
    output logic             conv_swap_o,
    output logic             buf_enable_o,
    input  wire logic        conv_done_i,
    input  wire logic [13:0] conv_result_i
);

    logic [4:0]                setup_one;
    logic [5:0]                setup_two;
    logic                      result_valid;
    mas_pkg::mas_state_t       state;
    mas_pkg::mas_state_t       next_state;
    logic [2:0]                next_channel;
    logic [13:0]               readback;

    wire       enable      = setup_one[mas_pkg::BIT_CONVERTER_ENABLE - 3];
    wire       single_pass = setup_one[mas_pkg::BIT_SINGLE_PASS - 3];
    wire       sweep       = setup_one[mas_pkg::BIT_ALL_CHANNEL_SWEEP - 3];
    wire       bypass      = setup_one[mas_pkg::BIT_BUFFER_BYPASS - 3];
    wire       swap        = setup_one[mas_pkg::BIT_INPUT_SWAP - 3];
    wire [2:0] rd_sel      = setup_two[mas_pkg::RDSEL_HI:mas_pkg::RDSEL_LO];
    wire [2:0] cv_sel      = setup_two[mas_pkg::CVSEL_HI:mas_pkg::CVSEL_LO];

    wire wr_one   = reg_wr_i && (reg_addr_i == mas_pkg::OFS_CONVERTER_SETUP_ONE);
    wire wr_two   = reg_wr_i && (reg_addr_i == mas_pkg::OFS_CONVERTER_SETUP_TWO);
    wire finished = (state == mas_pkg::MAS_WAIT) && conv_done_i && enable;
    wire last_ch  = (conv_channel_o == mas_pkg::CH_ANALOG_GROUND_REFERENCE);

    // register images, reserved bits read as zero
    wire [7:0] img_high = readback[mas_pkg::RESULT_W-1:mas_pkg::RES_HIGH_LO];
    wire [7:0] img_low  = {2'h0, readback[mas_pkg::RES_HIGH_LO-1:0]};
    wire [7:0] img_one  = {setup_one, SILICON_REVISION};
    wire [7:0] img_two  = {result_valid, 1'b0, setup_two};

    wire [7:0] rd_mux;
    assign rd_mux = (reg_addr_i == mas_pkg::OFS_RESULT_HIGH_BYTE)    ? img_high :
                    (reg_addr_i == mas_pkg::OFS_RESULT_LOW_BITS)     ? img_low  :
                    (reg_addr_i == mas_pkg::OFS_CONVERTER_SETUP_ONE) ? img_one  :
                    (reg_addr_i == mas_pkg::OFS_CONVERTER_SETUP_TWO) ? img_two  :
                    mas_pkg::UNMAPPED_DATA;

    mas_result_store #(
        .WIDTH (mas_pkg::RESULT_W),
        .DEPTH (mas_pkg::NUM_CHAN),
        .AW    (mas_pkg::CHAN_W)
    ) u_store (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .wr_en_i   (finished),
        .wr_ch_i   (conv_channel_o),
        .wr_data_i (conv_result_i),
        .rd_ch_i   (rd_sel),
        .rd_data_o (readback)
    );

    // sequencer
    always_comb begin
        next_state   = state;
        next_channel = conv_channel_o;
        case (state)
            mas_pkg::MAS_IDLE: begin
                if (enable) begin
                    next_state   = mas_pkg::MAS_START;
                    next_channel = sweep ? mas_pkg::CH_INPUT_LIMIT_PIN : cv_sel;
                end
            end
            mas_pkg::MAS_START: begin
                next_state = enable ? mas_pkg::MAS_WAIT : mas_pkg::MAS_IDLE;
            end
            mas_pkg::MAS_WAIT: begin
                if (!enable) begin
                    next_state = mas_pkg::MAS_IDLE;
                end else if (conv_done_i) begin
                    if (sweep) begin
                        if (last_ch && single_pass) begin
                            next_state = mas_pkg::MAS_HALT;
                        end else begin
                            next_state   = mas_pkg::MAS_START;
                            next_channel = 3'(conv_channel_o + 3'h1);
                        end
                    end else if (single_pass) begin
                        next_state = mas_pkg::MAS_HALT;
                    end else begin
                        next_state   = mas_pkg::MAS_START;
                        next_channel = cv_sel;
                    end
                end
            end
            mas_pkg::MAS_HALT: begin
                // a fresh single pass needs the enable bit cleared and set again
                if (!enable) begin
                    next_state = mas_pkg::MAS_IDLE;
                end
            end
            default: begin
                next_state = mas_pkg::MAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state          <= mas_pkg::MAS_IDLE;
            conv_channel_o <= mas_pkg::CH_INPUT_LIMIT_PIN;
            conv_start_o   <= 1'b0;
        end else begin
            state          <= next_state;
            conv_channel_o <= next_channel;
            conv_start_o   <= (next_state == mas_pkg::MAS_START);
        end
    end

    // registers; valid set wins over the clear at run start
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            setup_one    <= mas_pkg::SETUP_ONE_RST;
            setup_two    <= mas_pkg::SETUP_TWO_RST;
            result_valid <= 1'b0;
            reg_rdata_o  <= mas_pkg::RDATA_RST;
            conv_swap_o  <= 1'b0;
            buf_enable_o <= 1'b1;
        end else begin
            if (wr_one) begin
                setup_one <= reg_wdata_i[7:3];
            end
            if (wr_two) begin
                setup_two <= reg_wdata_i[5:0];
            end
            if (finished) begin
                result_valid <= 1'b1;
            end else if (state == mas_pkg::MAS_IDLE && enable) begin
                result_valid <= 1'b0;
            end
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
            conv_swap_o  <= swap;
            buf_enable_o <= !bypass;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_start_needs_en: assert property (conv_start_o |-> $past(enable))
        else $error("start issued while disabled");
    a_cont_restart: assert property (finished && !single_pass |=> conv_start_o)
        else $error("continuous mode did not restart");
    a_fixed_chan: assert property (finished && !single_pass && !sweep
        |=> conv_channel_o == $past(cv_sel))
        else $error("repeat mode left the selected channel");
    a_sweep_step: assert property (finished && sweep && !last_ch
        |=> conv_channel_o == 3'($past(conv_channel_o) + 3'h1))
        else $error("sweep did not advance by one");
    a_sweep_wrap: assert property (finished && sweep && last_ch && !single_pass
        |=> conv_channel_o == mas_pkg::CH_INPUT_LIMIT_PIN ##1 conv_start_o == 1'b0)
        else $error("sweep did not wrap to channel zero");
    a_single_stop: assert property (finished && single_pass && !sweep
        |=> state == mas_pkg::MAS_HALT && !conv_start_o)
        else $error("single pass did not stop");
    a_sweep_halt: assert property (finished && single_pass && sweep && last_ch
        |=> state == mas_pkg::MAS_HALT && !conv_start_o
        ##1 (state == mas_pkg::MAS_HALT || !$past(enable)))
        else $error("one-loop sweep did not halt");
    a_valid_set: assert property (finished |=> result_valid)
        else $error("result valid not set after conversion");
    a_valid_clear: assert property (state == mas_pkg::MAS_IDLE && enable
        |=> !result_valid && conv_start_o)
        else $error("result valid not cleared at run start");
    a_rev_fixed: assert property (reg_rd_i && reg_addr_i == mas_pkg::OFS_CONVERTER_SETUP_ONE
        |=> reg_rdata_o[2:0] == SILICON_REVISION)
        else $error("revision field not constant");
    a_low_reserved: assert property (reg_rd_i && reg_addr_i == mas_pkg::OFS_RESULT_LOW_BITS
        |=> reg_rdata_o[7:6] == 2'h0)
        else $error("reserved result bits not zero");
    a_swap_follow: assert property ($changed(swap) |=> conv_swap_o == $past(swap))
        else $error("swap output did not follow bit");

endmodule : mas_sequencer

// *** mas_conv_model.sv ***
/*
 * mas_conv_model: behavioural stand-in for the analog converter.
 * assumes: one done pulse per start, delay_i extra cycles, delay 0 answers
 * in the cycle right after the start pulse.
 */
`timescale 1ns/1ps
module mas_conv_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // converter side
    input  wire logic        conv_start_i,
    input  wire logic [2:0]  conv_channel_i,
    input  wire logic [3:0]  delay_i,
    output logic             conv_done_o,
    output logic      [13:0] conv_result_o,
    // observation
    output logic      [15:0] start_count_o,
    output logic      [2:0]  last_ch_o
);
    logic [3:0]  cnt;
    logic        busy;
    logic [13:0] res;
    // result only valid with done; otherwise show the inverse so stale data is not trusted
    assign conv_result_o = conv_done_o ? res : ~res;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {cnt, busy, res, conv_done_o, start_count_o, last_ch_o} <= '0;
        end else begin
            conv_done_o <= 1'b0;
            if (conv_start_i) begin
                start_count_o <= start_count_o + 16'h0001;
                last_ch_o     <= conv_channel_i;
                res           <= {conv_channel_i, conv_channel_i, conv_channel_i,
                                  conv_channel_i, conv_channel_i[1:0]};
                cnt           <= delay_i;
                busy          <= (delay_i != 4'h0);
                conv_done_o   <= (delay_i == 4'h0);
            end else if (busy) begin
                cnt         <= cnt - 4'h1;
                busy        <= (cnt > 4'h1);
                conv_done_o <= (cnt == 4'h1);
            end
        end
    end
endmodule : mas_conv_model

// *** monitor_adc_sequencer_bench.sv ***
/*
 * monitor_adc_sequencer_bench: self-checking bench of the sequencer.
 * assumes: converter model answers every start; revision parameter left at 0.
 */
`timescale 1ns/1ps
module monitor_adc_sequencer_bench;
    logic        clk_i       = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_rd_i    = 1'b0;
    logic [3:0]  delay_i     = 4'h0;
    logic [7:0]  reg_rdata_o;
    logic        conv_start_o, conv_swap_o, buf_enable_o, conv_done_i;
    logic [2:0]  conv_channel_o, last_ch;
    logic [13:0] conv_result_i;
    logic [15:0] starts, s0;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    mas_sequencer u_mas_sequencer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
        .conv_channel_o(conv_channel_o), .conv_swap_o(conv_swap_o),
        .buf_enable_o(buf_enable_o), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i));
    mas_conv_model u_mas_conv_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .conv_start_i(conv_start_o), .conv_channel_i(conv_channel_o), .delay_i(delay_i),
        .conv_done_o(conv_done_i), .conv_result_o(conv_result_i),
        .start_count_o(starts), .last_ch_o(last_ch));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // sweeps are short; a hang shows as thousands of idle cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            close_out();
        end
    end
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [13:0] res_of(input logic [2:0] c);
        return {c, c, c, c, c[1:0]};
    endfunction : res_of
    task idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= v;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : rd
    task t_reset;
        logic [7:0] v;
        rd(8'h07, v); chk("high byte", 16'h0000, v);
        rd(8'h08, v); chk("low bits", 16'h0000, v);
        rd(8'h09, v); chk("setup one", 16'h0000, v);
        rd(8'h0A, v); chk("setup two", 16'h0000, v);
        rd(8'h0B, v); chk("unmapped", 16'h0000, v);
        chk("buffer enable", 16'h0001, buf_enable_o);
    endtask : t_reset
    task t_fields;
        logic [7:0] v;
        wr(8'h09, 8'h1F); idle(2);
        chk("swap", 16'h0001, conv_swap_o);
        chk("buffer off", 16'h0000, buf_enable_o);
        rd(8'h09, v); chk("revision kept", 16'h0018, v);
        wr(8'h09, 8'h00); idle(2);
        chk("swap clear", 16'h0000, conv_swap_o);
        chk("buffer on", 16'h0001, buf_enable_o);
        wr(8'h0A, 8'h80); rd(8'h0A, v); chk("read only bits", 16'h0000, v);
        wr(8'h07, 8'hFF); rd(8'h07, v); chk("ro high", 16'h0000, v);
    endtask : t_fields
    task t_single;
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            delay_i <= (c % 2 == 0) ? 4'h0 : 4'h5;
            wr(8'h0A, {2'b00, c[2:0], c[2:0]});
            s0 = starts;
            wr(8'h09, 8'hC0); idle(30);
            chk("single count", 16'h0001, starts - s0);
            chk("single ch", {13'h0, c[2:0]}, last_ch);
            rd(8'h0A, v); chk("valid", {8'h0, 2'b10, c[2:0], c[2:0]}, v);
            rd(8'h07, v); chk("res high", res_of(c[2:0]) >> 6, v);
            rd(8'h08, v); chk("res low", 16'(res_of(c[2:0]) & 14'h003F), v);
            wr(8'h09, 8'h00);
        end
    endtask : t_single
    task t_once_sweep;
        logic [7:0] v;
        delay_i <= 4'h2;
        s0 = starts;
        wr(8'h09, 8'hE0); idle(80);
        chk("one loop count", 16'h0008, starts - s0);
        chk("one loop last", 16'h0007, last_ch);
        for (int c = 0; c < 8; c++) begin
            wr(8'h0A, {2'b00, c[2:0], 3'h0});
            rd(8'h07, v); chk("slot high", res_of(c[2:0]) >> 6, v);
            rd(8'h08, v); chk("slot low", 16'(res_of(c[2:0]) & 14'h003F), v);
        end
        wr(8'h09, 8'h00);
    endtask : t_once_sweep
    task t_loop;
        logic [7:0] v;
        delay_i <= 4'h5;
        wr(8'h0A, 8'h2A);
        s0 = starts;
        wr(8'h09, 8'h80);
        rd(8'h0A, v); chk("valid cleared", 16'h002A, v);
        idle(20);
        rd(8'h07, v); chk("other slot", res_of(3'h5) >> 6, v);
        idle(80);
        wr(8'h09, 8'h00); idle(10);
        chk("loop ch", 16'h0002, last_ch);
        chk("loop runs", 16'h0001, (starts - s0) > 16'h8);
        s0 = starts; idle(20);
        chk("stopped", s0, starts);
    endtask : t_loop
    task t_sweep_loop;
        logic [15:0] n;
        delay_i <= 4'h0;
        s0 = starts;
        wr(8'h09, 8'hA0); idle(100);
        wr(8'h09, 8'h00); idle(5);
        n = starts - s0;
        chk("sweep wraps", 16'h0001, n > 16'h8);
        chk("sweep order", (n - 16'h1) % 16'h8, last_ch);
    endtask : t_sweep_loop
    // one reading with swap clear, one with swap set, then the host average
    task t_swap_avg;
        logic [7:0]  hi;
        logic [7:0]  lo;
        logic [14:0] sum;
        sum = 15'h0000;
        delay_i <= 4'h3;
        wr(8'h0A, 8'h2D);
        for (int s = 0; s < 2; s++) begin
            wr(8'h09, s[0] ? 8'hC8 : 8'hC0);
            idle(20);
            chk("swap level", {15'h0000, s[0]}, conv_swap_o);
            rd(8'h07, hi);
            rd(8'h08, lo);
            sum = sum + {1'b0, hi, lo[5:0]};
            wr(8'h09, 8'h00);
        end
        chk("swap average", {2'h0, res_of(3'h5)}, 16'(sum >> 1));
    endtask : t_swap_avg
    initial begin
        idle(10);
        sys_rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_single();
        t_once_sweep();
        t_loop();
        t_sweep_loop();
        t_swap_avg();
        close_out();
    end
endmodule : monitor_adc_sequencer_bench
